/* inc/sdsc_consts.vh */
`ifndef SDSC_CONSTS_VH
`define SDSC_CONSTS_VH

// APB register offsets (byte addresses)
`define SDSC_CTRL_OFS 12'h000
`define SDSC_STAT_OFS 12'h004

// Control register fields
`define SDSC_CTRL_TO_OFF_BIT 0
`define SDSC_CTRL_PWR_ON_BIT 1
`define SDSC_CTRL_RST 32'h0000_0001

// Status register fields
`define SDSC_ST_SERIAL_BIT 0
`define SDSC_ST_QUIET_BIT 1
`define SDSC_ST_WAKING_BIT 2
`define SDSC_ST_POL_BIT 3
`define SDSC_ST_CURRENT_LIMIT_LEVEL_LSB 4
`define SDSC_ST_ADDR_LSB 8
`define SDSC_ST_PTR_LSB 16

// Strap codes at or below this value are the lower eight levels
`define SDSC_STRAP_LOW_MAX 4'h7

// Client address groups
`define SDSC_ADDR_HI_GRP 5'h15
`define SDSC_ADDR_LO_GRP 5'h0c

// Times in their own units, and the clock rate
`define SDSC_CLK_MHZ 100
`define SDSC_QUIET_US 5500
`define SDSC_WAKE_US 3000
`define SDSC_LOW_TO_US 30000
`define SDSC_IDLE_TO_US 200

// Cycles after reset release before the straps are taken
`define SDSC_STRAP_WAIT 4'h8

// Byte returned while the device is asleep or still waking
`define SDSC_INVALID_BYTE 8'hff

`endif

/* rtl/sdsc_sync.v */
`timescale 1ns/1ps
`default_nettype none

module sdsc_sync #(
    parameter W = 1,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    // Clock and reset
    input wire clock_i,
    input wire rstn_i,
    input wire ce_i,
    // Asynchronous input and synchronised output
    input wire [W-1:0] async_i,
    output wire [W-1:0] sync_o
);

    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // Two flops per bit; first stage feeds only the second
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            always @(posedge clock_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    meta_q[i] <= RST_VAL[i];
                    sync_q[i] <= RST_VAL[i];
                end else if (ce_i) begin
                    meta_q[i] <= async_i[i];
                    sync_q[i] <= meta_q[i];
                end
            end
        end
    endgenerate

    assign sync_o = sync_q;

endmodule

`default_nettype wire

/* rtl/sdsc_strap_decode.v */
`timescale 1ns/1ps
`default_nettype none
`include "sdsc_consts.vh"

module sdsc_strap_decode (
    // Digitised strap levels, 0 = ground .. 15 = tie high
    input wire [3:0] mode_code_i,
    input wire [3:0] addr_code_i,
    // Decoded settings
    output reg serial_mode_o,
    output reg [2:0] current_limit_level_o,
    output reg [6:0] client_addr_o,
    output reg pwr_active_high_o
);

    reg [2:0] idx;

    // Straps fold into eight levels; only the address strap is mirrored across the two halves
    always @* begin
        serial_mode_o = (mode_code_i <= `SDSC_STRAP_LOW_MAX);
        current_limit_level_o = mode_code_i[2:0];
        pwr_active_high_o = (addr_code_i > `SDSC_STRAP_LOW_MAX);
        // Upper half walks back down the same table
        if (addr_code_i > `SDSC_STRAP_LOW_MAX) begin
            idx = ~addr_code_i[2:0];
        end else begin
            idx = addr_code_i[2:0];
        end
        // First four: 1010_111 downward, next four: 0110_000 upward
        if (!idx[2]) begin
            client_addr_o = {`SDSC_ADDR_HI_GRP, ~idx[1:0]};
        end else begin
            client_addr_o = {`SDSC_ADDR_LO_GRP, idx[1:0]};
        end
    end

endmodule

`default_nettype wire

/* rtl/sdsc_client.v */
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "sdsc_consts.vh"

module sdsc_client #(
    parameter integer QUIET_CYC = `SDSC_QUIET_US * `SDSC_CLK_MHZ,
    parameter integer WAKE_CYC = `SDSC_WAKE_US * `SDSC_CLK_MHZ,
    parameter integer LOW_TO_CYC = `SDSC_LOW_TO_US * `SDSC_CLK_MHZ,
    parameter integer IDLE_TO_CYC = `SDSC_IDLE_TO_US * `SDSC_CLK_MHZ
) (
    // Clock, reset, enable
    input wire clock_i,
    input wire rstn_i,
    input wire ce_i,
    // Digitised straps (asynchronous)
    input wire [3:0] mode_and_limit_strap_i,
    input wire [3:0] addr_strap_i,
    // Two-wire bus pins
    input wire bus_clock_line_i,
    input wire sda_i,
    output wire sda_o,
    output wire sda_oe_o,
    // Register map side
    output wire [7:0] reg_ptr_o,
    output wire [7:0] reg_wdata_o,
    output wire reg_we_o,
    input wire [7:0] reg_rdata_i,
    // Power state
    input wire sleep_i,
    output wire wake_o,
    output wire serial_mode_o,
    output wire [2:0] current_limit_level_o,
    output wire port_power_switch_control_o,
    // APB slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output wire pready_o,
    output wire [31:0] prdata_o,
    output wire pslverr_o
);

    // Interface states
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_RX = 3'h1;
    localparam [2:0] ST_RACK = 3'h2;
    localparam [2:0] ST_TX = 3'h3;
    localparam [2:0] ST_HACK = 3'h4;
    localparam [2:0] ST_IGN = 3'h5;

    localparam [22:0] QUIET_N = QUIET_CYC[22:0];
    localparam [22:0] WAKE_N = WAKE_CYC[22:0];
    localparam [22:0] LOW_TO_N = LOW_TO_CYC[22:0];
    localparam [22:0] IDLE_TO_N = IDLE_TO_CYC[22:0];

    wire [9:0] strap_s;
    wire [1:0] bus_s;
    wire scl_s = bus_s[1];
    wire sda_s = bus_s[0];
    wire dec_serial;
    wire [2:0] dec_current_limit_level;
    wire [6:0] dec_addr;
    wire dec_pol_hi;

    reg scl_q, sda_q;
    reg [3:0] strap_cnt_q;
    reg strap_done_q;
    reg serial_q, pol_hi_q;
    reg [2:0] current_limit_level_q;
    reg [6:0] addr_q;
    reg [22:0] quiet_cnt_q;
    reg [22:0] wake_cnt_q;
    reg [22:0] low_cnt_q;
    reg [22:0] idle_cnt_q;
    reg [2:0] state_q;
    reg [3:0] bit_q;
    reg [7:0] shift_q;
    reg addr_phase_q;
    reg ptr_loaded_q;
    reg read_q;
    reg host_ack_q;
    reg oe_q;
    reg [7:0] ptr_q;
    reg [7:0] wdata_q;
    reg we_q;
    reg step_q;
    reg wake_q;
    reg [31:0] ctrl_q;
    reg [31:0] prdata_q;
    reg pslverr_q;

    // Straps and bus lines come from outside the clock domain
    sdsc_sync #(.W(10), .RST_VAL(10'h000)) u_strap_sync (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .async_i({mode_and_limit_strap_i, addr_strap_i, 2'b00}),
        .sync_o(strap_s)
    );

    sdsc_sync #(.W(2), .RST_VAL(2'h3)) u_bus_sync (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .async_i({bus_clock_line_i, sda_i}),
        .sync_o(bus_s)
    );

    sdsc_strap_decode u_decode (
        .mode_code_i(strap_s[9:6]),
        .addr_code_i(strap_s[5:2]),
        .serial_mode_o(dec_serial),
        .current_limit_level_o(dec_current_limit_level),
        .client_addr_o(dec_addr),
        .pwr_active_high_o(dec_pol_hi)
    );

    // Line events from the synchronised copies
    wire scl_rise = scl_s & ~scl_q;
    wire scl_fall = ~scl_s & scl_q;
    wire start_ev = scl_s & scl_q & sda_q & ~sda_s;
    wire stop_ev = scl_s & scl_q & ~sda_q & sda_s;
    wire quiet = (quiet_cnt_q != 23'h000000);
    wire waking = (wake_cnt_q != 23'h000000);
    wire to_off = ctrl_q[`SDSC_CTRL_TO_OFF_BIT];
    // Timeouts only act when software clears the off bit
    wire low_to = ~to_off & (low_cnt_q >= LOW_TO_N);
    wire idle_to = ~to_off & ~sleep_i & (idle_cnt_q >= IDLE_TO_N);
    wire client_on = strap_done_q & serial_q & ~quiet;

    // Straps are taken a few cycles after reset release, then held
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            strap_cnt_q <= 4'h0;
            strap_done_q <= 1'b0;
            serial_q <= 1'b0;
            pol_hi_q <= 1'b0;
            current_limit_level_q <= 3'h0;
            addr_q <= 7'h00;
        end else if (ce_i && !strap_done_q) begin
            strap_cnt_q <= strap_cnt_q + 4'h1;
            if (strap_cnt_q == `SDSC_STRAP_WAIT) begin
                strap_done_q <= 1'b1;
                serial_q <= dec_serial;
                pol_hi_q <= dec_pol_hi;
                current_limit_level_q <= dec_current_limit_level;
                addr_q <= dec_addr;
            end
        end
    end

    // Power-up quiet time, wake time and bus timeout counters
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            quiet_cnt_q <= QUIET_N;
            wake_cnt_q <= 23'h000000;
            low_cnt_q <= 23'h000000;
            idle_cnt_q <= 23'h000000;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else if (ce_i) begin
            scl_q <= scl_s;
            sda_q <= sda_s;
            if (quiet) begin
                quiet_cnt_q <= quiet_cnt_q - 23'h000001;
            end
            if (wake_q) begin
                wake_cnt_q <= WAKE_N;
            end else if (waking) begin
                wake_cnt_q <= wake_cnt_q - 23'h000001;
            end
            // Host may hold the clock low; only the timeout limits it
            if (scl_s || low_to) begin
                low_cnt_q <= 23'h000000;
            end else begin
                low_cnt_q <= low_cnt_q + 23'h000001;
            end
            if (!(scl_s && sda_s) || idle_to) begin
                idle_cnt_q <= 23'h000000;
            end else if (!idle_to) begin
                idle_cnt_q <= idle_cnt_q + 23'h000001;
            end
        end
    end

    // Client state machine; clock line is never driven
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= ST_IDLE;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            addr_phase_q <= 1'b0;
            ptr_loaded_q <= 1'b0;
            read_q <= 1'b0;
            host_ack_q <= 1'b0;
            oe_q <= 1'b0;
            ptr_q <= 8'h00;
            wdata_q <= 8'h00;
            we_q <= 1'b0;
            step_q <= 1'b0;
            wake_q <= 1'b0;
        end else if (ce_i) begin
            we_q <= 1'b0;
            wake_q <= 1'b0;
            if (stop_ev || low_to || idle_to) begin
                state_q <= ST_IDLE;
                oe_q <= 1'b0;
            end else if (start_ev) begin
                // Repeated start keeps the pointer
                oe_q <= 1'b0;
                bit_q <= 4'h0;
                addr_phase_q <= 1'b1;
                ptr_loaded_q <= 1'b0;
                state_q <= client_on ? ST_RX : ST_IGN;
            end else begin
                case (state_q)
                    ST_RX: begin
                        if (scl_rise) begin
                            shift_q <= {shift_q[6:0], sda_s};
                            bit_q <= bit_q + 4'h1;
                        end else if (scl_fall && bit_q == 4'h8) begin
                            bit_q <= 4'h0;
                            if (addr_phase_q) begin
                                addr_phase_q <= 1'b0;
                                read_q <= shift_q[0];
                                if (shift_q[7:1] == addr_q) begin
                                    oe_q <= 1'b1;
                                    state_q <= ST_RACK;
                                    wake_q <= shift_q[0] & sleep_i;
                                end else begin
                                    state_q <= ST_IGN;
                                end
                            end else begin
                                oe_q <= 1'b1;
                                state_q <= ST_RACK;
                                if (!ptr_loaded_q) begin
                                    ptr_q <= shift_q;
                                    ptr_loaded_q <= 1'b1;
                                end else begin
                                    // Writes while asleep are dropped
                                    wdata_q <= shift_q;
                                    we_q <= ~sleep_i & ~waking;
                                    // Write strobe is one cycle; keep step
                                    step_q <= ~sleep_i & ~waking;
                                end
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_fall) begin
                            // After a data write, step the pointer
                            if (step_q) begin
                                ptr_q <= ptr_q + 8'h01;
                            end
                            step_q <= 1'b0;
                            if (read_q) begin
                                // Read without address uses current pointer
                                shift_q <= (sleep_i || waking) ?
                                    `SDSC_INVALID_BYTE : reg_rdata_i;
                                oe_q <= ~reg_rdata_i[7] & ~sleep_i & ~waking;
                                bit_q <= 4'h1;
                                state_q <= ST_TX;
                            end else begin
                                oe_q <= 1'b0;
                                state_q <= ST_RX;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_fall) begin
                            if (bit_q == 4'h8) begin
                                oe_q <= 1'b0;
                                state_q <= ST_HACK;
                                ptr_q <= ptr_q + 8'h01;
                            end else begin
                                oe_q <= ~shift_q[6];
                                shift_q <= {shift_q[6:0], 1'b0};
                                bit_q <= bit_q + 4'h1;
                            end
                        end
                    end
                    ST_HACK: begin
                        if (scl_rise) begin
                            host_ack_q <= ~sda_s;
                        end else if (scl_fall) begin
                            if (host_ack_q) begin
                                shift_q <= (sleep_i || waking) ?
                                    `SDSC_INVALID_BYTE : reg_rdata_i;
                                oe_q <= ~reg_rdata_i[7] & ~sleep_i & ~waking;
                                bit_q <= 4'h1;
                                state_q <= ST_TX;
                            end else begin
                                state_q <= ST_IGN;
                            end
                        end
                    end
                    ST_IGN: begin
                        oe_q <= 1'b0;
                    end
                    default: begin
                        oe_q <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // APB slave: zero wait states, read data taken in setup cycle
    wire apb_setup = psel_i & ~penable_i;
    wire apb_wr = psel_i & penable_i & pwrite_i;
    wire hit_ctrl = (paddr_i == `SDSC_CTRL_OFS);
    wire hit_stat = (paddr_i == `SDSC_STAT_OFS);
    wire [31:0] stat_w;

    assign stat_w = {8'h00, ptr_q, 1'b0, addr_q, 1'b0, current_limit_level_q, pol_hi_q,
                     waking, quiet, serial_q};

    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_q <= `SDSC_CTRL_RST;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (ce_i) begin
            if (apb_setup) begin
                pslverr_q <= ~(hit_ctrl | (hit_stat & ~pwrite_i));
                if (hit_ctrl) begin
                    prdata_q <= {30'h0, ctrl_q[1:0]};
                end else if (hit_stat) begin
                    prdata_q <= stat_w;
                end else begin
                    prdata_q <= 32'h0000_0000;
                end
            end
            // Only the two control bits are kept
            if (apb_wr && hit_ctrl) begin
                ctrl_q <= {30'h0, pwdata_i[1:0]};
            end
        end
    end

    // Outputs
    assign sda_o = 1'b0;
    assign sda_oe_o = oe_q;
    assign reg_ptr_o = ptr_q;
    assign reg_wdata_o = wdata_q;
    assign reg_we_o = we_q;
    assign wake_o = wake_q;
    assign serial_mode_o = serial_q;
    assign current_limit_level_o = current_limit_level_q;
    // Polarity follows the address strap
    assign port_power_switch_control_o =
        ctrl_q[`SDSC_CTRL_PWR_ON_BIT] ~^ pol_hi_q;
    assign pready_o = 1'b1;
    assign prdata_o = prdata_q;
    assign pslverr_o = pslverr_q & psel_i & penable_i;

endmodule

`default_nettype wire

/* dv/sdsc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Behavioural bus host; both lines rest high between frames
module sdsc_host_model (
    // Clock and sensed data wire
    input wire logic clock_i,
    input wire logic sda_i,
    // Driven lines, 1 = released
    output logic scl_o,
    output logic sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    // Extra low time first: a late ACK release must not look like a stop
    task automatic start();
        wt(4);
        sda_o <= 1'b1;
        wt(2);
        scl_o <= 1'b1;
        wt(4);
        sda_o <= 1'b0;
        wt(4);
        scl_o <= 1'b0;
        wt(2);
    endtask
    task automatic stop();
        sda_o <= 1'b0;
        wt(2);
        scl_o <= 1'b1;
        wt(4);
        sda_o <= 1'b1;
        wt(4);
    endtask
    // One bit each way, read late in the high phase
    task automatic bit_io(input logic b, output logic r);
        sda_o <= b;
        wt(2);
        scl_o <= 1'b1;
        wt(4);
        r = sda_i;
        scl_o <= 1'b0;
        wt(2);
    endtask
    // Eight bits then the ninth; 80 ns per bit
    task automatic xfer(input logic [7:0] tx, input logic ai,
                        output logic [7:0] rx, output logic ao);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(ai, ao);
    endtask
endmodule
`default_nettype wire

/* dv/sdsc_client_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on the bus client
module sdsc_client_checker #(
    parameter integer QUIET_CYC = 200
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // Bus pins
    input wire logic bus_clock_line_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    // Register side and power state
    input wire logic [7:0] reg_ptr_o,
    input wire logic reg_we_o,
    input wire logic sleep_i,
    input wire logic wake_o,
    input wire logic serial_mode_o,
    // APB
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic pready_o,
    input wire logic pslverr_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    logic [31:0] quiet_q;
    logic [7:0] we_ptr_q;
    // Quiet window from reset; the design starts later, so this is safe
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            quiet_q <= 32'h0;
            we_ptr_q <= 8'h0;
        end else begin
            if (ce_i && quiet_q < QUIET_CYC) quiet_q <= quiet_q + 32'h1;
            if (reg_we_o) we_ptr_q <= reg_ptr_o;
        end
    end
    chk_quiet_silent: assert property (
        quiet_q < QUIET_CYC |-> !sda_oe_o)
        else $error("data pulled during quiet time");
    chk_standalone_mute: assert property (
        !serial_mode_o |-> !sda_oe_o)
        else $error("data pulled in stand-alone mode");
    chk_open_drain: assert property (
        sda_oe_o |-> sda_o == 1'b0)
        else $error("data driven high");
    chk_ack_holds: assert property (
        $rose(sda_oe_o) |=> sda_oe_o [*3])
        else $error("acknowledge too short");
    chk_ptr_step: assert property (
        reg_we_o |-> ##[1:40] reg_ptr_o == we_ptr_q + 8'h01)
        else $error("pointer not stepped after write");
    chk_wake_pulse: assert property (
        wake_o |-> (sleep_i || $past(sleep_i)) ##1 !wake_o)
        else $error("wake pulse wrong");
    chk_stop_idle: assert property (
        bus_clock_line_i && $rose(sda_i) |=> !sda_oe_o [*3])
        else $error("data pulled after stop");
    chk_unmapped_err: assert property (
        psel_i && penable_i && paddr_i > 12'h004 |-> pslverr_o)
        else $error("unmapped access without error");
    chk_status_ro: assert property (
        psel_i && penable_i && pwrite_i && paddr_i == 12'h004 |-> pslverr_o)
        else $error("status write without error");
    chk_ctrl_ok: assert property (
        psel_i && penable_i && paddr_i == 12'h000 |-> pready_o && !pslverr_o)
        else $error("control access refused");
endmodule
bind sdsc_client sdsc_client_checker #(.QUIET_CYC(QUIET_CYC)) u_chk (
    .clock_i, .rstn_i, .ce_i, .bus_clock_line_i, .sda_i, .sda_o, .sda_oe_o,
    .reg_ptr_o, .reg_we_o, .sleep_i, .wake_o, .serial_mode_o, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pready_o, .pslverr_o);
`default_nettype wire

/* dv/strap_decode_smbus_client_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module strap_decode_smbus_client_tb_top;
    localparam int QUIET = 200;
    localparam int WAKE = 100;
    localparam logic [6:0] ME = 7'h32;
    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic sleep = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    wire logic scl, host_sda, sda_o, sda_oe, we, wake, serial, pwr;
    wire logic pready, pslverr;
    wire logic [7:0] ptr, wdata;
    wire logic [2:0] current_limit_level;
    wire logic [31:0] prdata;
    // Wired-and data line with pull-up
    wire logic sda = host_sda & (sda_oe ? sda_o : 1'b1);
    int n_fail = 0, compares = 0, n_we = 0, n_wake = 0, cyc = 0;
    logic [15:0] we_log [0:7];
    logic [31:0] rd;
    logic err, ack;
    logic [7:0] rx;

    always #5 clock_i = ~clock_i;

    // Straps: mode code 2, address code 9 (upper half)
    sdsc_client #(.QUIET_CYC(QUIET), .WAKE_CYC(WAKE), .LOW_TO_CYC(500),
        .IDLE_TO_CYC(300)) DUT (
        .clock_i(clock_i), .rstn_i(rstn_i), .ce_i(1'b1),
        .mode_and_limit_strap_i(4'h2), .addr_strap_i(4'h9),
        .bus_clock_line_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
        .reg_ptr_o(ptr), .reg_wdata_o(wdata), .reg_we_o(we),
        .reg_rdata_i(ptr ^ 8'ha5), .sleep_i(sleep), .wake_o(wake),
        .serial_mode_o(serial), .current_limit_level_o(current_limit_level),
        .port_power_switch_control_o(pwr), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata),
        .pslverr_o(pslverr));

    sdsc_host_model host (.clock_i(clock_i), .sda_i(sda), .scl_o(scl),
        .sda_o(host_sda));

    task cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task report_and_stop();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Zero-wait slave, but the master still waits for pready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        do @(posedge clock_i); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Log register writes and wake pulses; cut a hang short
    always @(posedge clock_i) begin
        if (we) begin
            we_log[n_we[2:0]] <= {ptr, wdata};
            n_we = n_we + 1;
        end
        if (wake) n_wake = n_wake + 1;
        cyc = cyc + 1;
        if (cyc == 6000) begin
            n_fail++;
            report_and_stop();
        end
    end

    initial begin
        repeat (3) @(posedge clock_i);
        rstn_i <= 1'b1;
        // Address byte inside the quiet time
        host.start();
        host.xfer({ME, 1'b0}, 1'b1, rx, ack);
        cmp("early ack", 1, ack);
        host.stop();
        $display("test quiet done");
        host.wt(QUIET + 50);
        // Strap decode and register access
        apb(0, 12'h000, 0);
        cmp("ctrl reset", 32'h1, rd);
        apb(1, 12'h000, 32'h3);
        @(posedge clock_i);
        cmp("power out", 1, pwr);
        apb(0, 12'h004, 0);
        cmp("status", 32'h3229, rd & 32'h00ff7f79);
        cmp("current_limit_level", 2, current_limit_level);
        cmp("serial", 1, serial);
        apb(1, 12'h004, 0);
        cmp("status write err", 1, err);
        apb(0, 12'h010, 0);
        cmp("unmapped err", 1, err);
        cmp("unmapped data", 0, rd);
        $display("test apb done");
        // Block write across the pointer wrap
        host.start();
        host.xfer({ME, 1'b0}, 1'b1, rx, ack);
        cmp("addr ack", 0, ack);
        host.xfer(8'hfe, 1'b1, rx, ack);
        cmp("ptr ack", 0, ack);
        host.xfer(8'h11, 1'b1, rx, ack);
        cmp("data ack", 0, ack);
        host.xfer(8'h34, 1'b1, rx, ack);
        cmp("data ack", 0, ack);
        host.stop();
        cmp("write count", 2, n_we);
        cmp("write 0", 16'hfe11, we_log[0]);
        cmp("write 1", 16'hff34, we_log[1]);
        apb(0, 12'h004, 0);
        cmp("ptr wrap", 0, rd & 32'h00ff0000);
        $display("test write done");
        // Pointer load, repeated start, two bytes, then a bare read
        host.start();
        host.xfer({ME, 1'b0}, 1'b1, rx, ack);
        host.xfer(8'h40, 1'b1, rx, ack);
        host.start();
        host.xfer({ME, 1'b1}, 1'b1, rx, ack);
        cmp("read addr ack", 0, ack);
        host.xfer(8'hff, 1'b0, rx, ack);
        cmp("read 0", 8'h40 ^ 8'ha5, rx);
        host.xfer(8'hff, 1'b1, rx, ack);
        cmp("read 1", 8'h41 ^ 8'ha5, rx);
        host.stop();
        host.start();
        host.xfer({ME, 1'b1}, 1'b1, rx, ack);
        host.xfer(8'hff, 1'b1, rx, ack);
        cmp("bare read", 8'h42 ^ 8'ha5, rx);
        host.stop();
        $display("test read done");
        // Foreign address: nothing acknowledged, nothing written
        host.start();
        host.xfer({7'h33, 1'b0}, 1'b1, rx, ack);
        cmp("foreign ack", 1, ack);
        host.xfer(8'h05, 1'b1, rx, ack);
        cmp("foreign data ack", 1, ack);
        host.stop();
        cmp("foreign writes", 2, n_we);
        $display("test foreign done");
        // Sleeping device wakes on the first read
        sleep <= 1'b1;
        host.start();
        host.xfer({ME, 1'b1}, 1'b1, rx, ack);
        cmp("sleep addr ack", 0, ack);
        host.xfer(8'hff, 1'b1, rx, ack);
        cmp("sleep data", 8'hff, rx);
        host.stop();
        sleep <= 1'b0;
        cmp("wake count", 1, n_wake);
        host.wt(WAKE + 20);
        $display("test wake done");
        report_and_stop();
    end
endmodule
`default_nettype wire
